// ==== dv/mpsr_i2c_host.sv ====
/* Two-wire bus master model that talks to the register bank.
   Assumes sda_w is the resolved wire: pulled up, pulled low by either party. */
`timescale 1ns/1ns
module mpsr_i2c_host (
  // Clock
  input wire logic core_clk,
  // Serial pins
  output logic scl,
  output logic sda_md,
  input wire logic sda_w
);
  // Idle bus at time zero: both lines released high.
  initial
  begin
    scl = 1'b1;
    sda_md = 1'b1;
  end

  // Six cycles per phase keep every level above the four cycles the port needs.
  task automatic ph();
    repeat (6) @(negedge core_clk);
  endtask

  // Data moves only while scl is low, so it never looks like a start or stop.
  task automatic bitx(input logic b, output logic r);
    sda_md = b;
    ph();
    scl = 1'b1;
    ph();
    r = sda_w;
    scl = 1'b0;
    ph();
  endtask

  task automatic start();
    sda_md = 1'b1;
    scl = 1'b1;
    ph();
    sda_md = 1'b0;
    ph();
    scl = 1'b0;
    ph();
  endtask

  task automatic stop();
    sda_md = 1'b0;
    ph();
    scl = 1'b1;
    ph();
    sda_md = 1'b1;
    ph();
  endtask

  // Bytes go out most significant bit first; the ninth bit is the answer.
  task automatic wbyte(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(v[i], r);
    bitx(1'b1, r);
    ack = !r;
  endtask

  // The last byte of a read is closed with a not-acknowledge.
  task automatic rbyte(input logic last, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(1'b1, v[i]);
    bitx(last, r);
  endtask
endmodule

// ==== dv/testbench.sv ====
/* Self-checking bench for the margin and power-save register bank.
   Assumes the host model in mpsr_i2c_host and one 50 MHz clock. */
`timescale 1ns/1ns
module testbench;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic psi_active = 1'b0;
  logic pwm_tick = 1'b0;
  logic scl, sda_md, sda_out, sda_oe_n, sda_w, ack, de, drop, add, all;
  logic [12:0] nb_trip, core_trip;
  logic [8:0] nb_low, core_high, core_low;
  logic [5:0] hyst;
  logic signed [10:0] nb_off, core_off;
  logic [7:0] d [3];
  int bad_count = 0;
  int samples_checked = 0;
  int steps = 0;

  always #10 core_clk = ~core_clk;
  // The pad pulls sda up; the device only ever pulls it low.
  assign sda_w = sda_md & (sda_oe_n | sda_out);
  // Phase step pulses of every kind are tallied here.
  always @(posedge core_clk) steps <= steps + int'(drop) + int'(add) + int'(all);

  mpsr_regs dut (.core_clk(core_clk), .arst_n(arst_n), .ce(1'b1), .scl_in(scl),
    .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .psi_active(psi_active),
    .pwm_tick(pwm_tick), .shed_count(3'h3), .nb_dac_target_voltage(12'h578),
    .core_dac_target_voltage(12'h640), .nb_overvoltage_trip(nb_trip),
    .nb_pg_low_mv(nb_low), .nb_offset_mv(nb_off), .core_overvoltage_trip(core_trip),
    .core_pg_high_mv(core_high), .core_pg_low_mv(core_low), .pg_hyst_mv(hyst),
    .core_offset_mv(core_off), .diode_emul_en(de), .phase_drop_step(drop),
    .phase_add_step(add), .phase_all_step(all));
  mpsr_i2c_host host (.core_clk(core_clk), .scl(scl), .sda_md(sda_md), .sda_w(sda_w));

  // ******************************************************************
  // Checking and bus tasks
  // ******************************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Every byte of a write must be acknowledged; settings land after stop.
  task automatic wr(input logic [7:0] addr, input int n);
    host.start();
    host.wbyte(8'h8c, ack);
    chk(16'(ack), 16'h1);
    host.wbyte(addr, ack);
    chk(16'(ack), 16'h1);
    for (int i = 0; i < n; i++)
    begin
      host.wbyte(d[i], ack);
      chk(16'(ack), 16'h1);
    end
    host.stop();
  endtask

  task automatic rd(input logic [7:0] addr, input int n);
    logic [7:0] v;
    wr(addr, 0);
    host.start();
    host.wbyte(8'h8d, ack);
    chk(16'(ack), 16'h1);
    for (int i = 0; i < n; i++)
    begin
      host.rbyte(i == n - 1, v);
      chk(16'(v), 16'(d[i]));
    end
    host.stop();
  endtask

  // Enter then leave power-savings mode, giving four PWM ticks each way.
  task automatic pace(input logic [1:0] c, input int exp_n);
    d[0] = {3'h0, c, c, 1'b0};
    wr(8'h02, 1);
    for (int k = 0; k < 2; k++)
    begin
      steps = 0;
      psi_active = !psi_active;
      repeat (4)
      begin
        repeat (3) @(negedge core_clk);
        pwm_tick = 1'b1;
        @(negedge core_clk);
        pwm_tick = 1'b0;
      end
      repeat (3) @(negedge core_clk);
      chk(16'(steps), 16'(exp_n));
      chk(16'(de), 16'h0);
    end
  endtask

  // A hung run is cut short and reported as a mismatch.
  initial
  begin
    repeat (90000) @(posedge core_clk);
    bad_count++;
    close_out();
  end

  // Main sequence.
  initial
  begin
    repeat (4) @(negedge core_clk);
    arst_n = 1'b1;
    repeat (4) @(negedge core_clk);
    chk(16'(nb_trip), 16'h0708);
    chk(16'(nb_low), 16'h012c);
    chk(16'(hyst), 16'h0032);
    d = '{8'h00, 8'h00, 8'h01};
    rd(8'h00, 3);
    d = '{8'hc1, 8'h3f, 8'hca};
    wr(8'h00, 3);
    chk(16'(nb_trip), 16'h076c);
    chk(16'(nb_low), 16'h015e);
    chk(16'(nb_off), 16'h0019);
    chk(16'(core_trip), 16'h073a);
    chk(16'(core_high), 16'h00fa);
    chk(16'(core_low), 16'h012c);
    chk(16'(core_off), 16'hffe7);
    rd(8'h00, 3);
    d[0] = 8'he0;
    wr(8'h01, 1);
    chk(16'(core_trip), 16'h0834);
    chk(16'(core_high), 16'h012c);
    chk(16'(core_low), 16'h015e);
    chk(16'(core_off), 16'hfce0);
    chk(16'(nb_off), 16'h0019);
    host.start();
    host.wbyte(8'h90, ack);
    chk(16'(ack), 16'h0);
    host.stop();
    d[0] = 8'h21;
    wr(8'h02, 1);
    psi_active = 1'b1;
    repeat (4) @(negedge core_clk);
    chk(16'(nb_off), 16'h0000);
    chk(16'(de), 16'h1);
    psi_active = 1'b0;
    repeat (4) @(negedge core_clk);
    chk(16'(nb_off), 16'h0019);
    pace(2'h0, 3);
    pace(2'h1, 2);
    pace(2'h2, 1);
    pace(2'h3, 1);
    close_out();
  end
endmodule

// ==== rtl/mpsr_if.sv ====
/*
 * Carriers between the register bank top and its two helper modules.
 * Assumes one clock domain; the top drives the inputs of each bundle.
 */
`timescale 1ns/1ns
// ********************************************************************
// Margin decoder bundle
// ********************************************************************
interface mpsr_margin_if;
  logic [7:0] cfg;
  logic apply_off;
  logic [11:0] dac_mv;
  logic [12:0] ovp_trip_mv;
  logic [8:0] pg_hi_mv;
  logic [8:0] pg_lo_mv;
  logic [5:0] pg_hyst_mv;
  logic signed [10:0] off_mv;
  modport ctl (output cfg, apply_off, dac_mv,
               input ovp_trip_mv, pg_hi_mv, pg_lo_mv, pg_hyst_mv, off_mv);
  modport dec (input cfg, apply_off, dac_mv,
               output ovp_trip_mv, pg_hi_mv, pg_lo_mv, pg_hyst_mv, off_mv);
endinterface

// ********************************************************************
// Phase pacer bundle
// ********************************************************************
interface mpsr_pace_if;
  logic psi_active;
  logic pwm_tick;
  logic [2:0] shed_count;
  logic [1:0] drop_code;
  logic [1:0] add_code;
  logic drop_step;
  logic add_step;
  logic all_step;
  modport ctl (output psi_active, pwm_tick, shed_count, drop_code, add_code,
               input drop_step, add_step, all_step);
  modport pac (input psi_active, pwm_tick, shed_count, drop_code, add_code,
               output drop_step, add_step, all_step);
endinterface

// ==== rtl/mpsr_margin_dec.sv ====
/*
 * Decodes one margin register into registered trip levels and offset.
 * Assumes the caller keeps cfg and dac_mv on core_clk.
 */
`timescale 1ns/1ns
module mpsr_margin_dec #(
  parameter bit IS_CORE = 1'b1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic ce,
  // Decoder bundle
  mpsr_margin_if.dec m
);
  logic [9:0] ovp_off;
  logic [12:0] ovp_sum;
  logic signed [10:0] off_raw;

  // Both regulators share this layout; only the upper power-good limit differs.
  always_comb
  begin
    ovp_off = m.cfg[mpsr_pkg::MG_OVP_BIT] ? mpsr_pkg::OVP_HI_MV : mpsr_pkg::OVP_LO_MV;
    ovp_sum = 13'(m.dac_mv) + 13'(ovp_off);
    off_raw = 11'($signed(m.cfg[mpsr_pkg::MG_OFF_MSB:0])) * $signed(mpsr_pkg::OFF_STEP_MV);
  end

  // Registered outputs; the offset drops to zero when the top withdraws it.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      m.ovp_trip_mv <= mpsr_pkg::OVP_FLOOR_MV;
      m.pg_hi_mv <= 9'h000;
      m.pg_lo_mv <= mpsr_pkg::PG_LO0_MV;
      m.pg_hyst_mv <= mpsr_pkg::PG_HYST_MV;
      m.off_mv <= 11'sh000;
    end
    else if (ce)
    begin
      m.ovp_trip_mv <= (ovp_sum > mpsr_pkg::OVP_FLOOR_MV) ? ovp_sum
                                                         : mpsr_pkg::OVP_FLOOR_MV;
      if (IS_CORE)
        m.pg_hi_mv <= m.cfg[mpsr_pkg::MG_PG_BIT] ? mpsr_pkg::PG_CORE_HI1_MV
                                                 : mpsr_pkg::PG_CORE_HI0_MV;
      else
        m.pg_hi_mv <= 9'h000;
      m.pg_lo_mv <= m.cfg[mpsr_pkg::MG_PG_BIT] ? mpsr_pkg::PG_LO1_MV : mpsr_pkg::PG_LO0_MV;
      m.pg_hyst_mv <= mpsr_pkg::PG_HYST_MV;
      m.off_mv <= m.apply_off ? off_raw : 11'sh000;
    end
  end

  // ******************************************************************
  // Checks
  // ******************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  offset_scale_a: assert property (ce && m.apply_off |=> m.off_mv == 11'($signed($past(m.cfg[5:0])) * 25))
    else $error("margin offset not 25 mV per code");
  offset_removed_a: assert property (ce && !m.apply_off |=> m.off_mv == 11'sh000)
    else $error("offset kept while withdrawn");
  ovp_level_a: assert property (ce |=> m.ovp_trip_mv >= 13'd1800 && m.ovp_trip_mv >= 13'($past(m.dac_mv)) + ($past(m.cfg[7]) ? 13'd500 : 13'd250))
    else $error("overvoltage trip below selected level");
  pg_window_a: assert property (ce |=> m.pg_lo_mv == ($past(m.cfg[6]) ? 9'd350 : 9'd300))
    else $error("power-good lower limit wrong");
  pg_hyst_a: assert property (ce |=> m.pg_hyst_mv == 6'd50)
    else $error("power-good hysteresis not 50 mV");
endmodule

// ==== rtl/mpsr_phase_pacer.sv ====
/*
 * Paces phase shedding on entry to power-savings mode and phase adding on
 * exit. Assumes pwm_tick is a one-cycle pulse per completed PWM cycle.
 */
`timescale 1ns/1ns
module mpsr_phase_pacer (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic ce,
  // Pacer bundle
  mpsr_pace_if.pac p
);
  logic psi_q;
  logic adding_q;
  logic [2:0] pending_q;
  logic [2:0] gap_q;
  logic [1:0] code;
  logic [2:0] space;
  logic [2:0] gap_n;
  logic drop_code_two;

  // Spacing in PWM cycles for a code; the all-at-once code is handled apart.
  function automatic logic [2:0] spacing(input logic [1:0] c);
    case (c)
      2'h0: spacing = 3'h1;
      2'h1: spacing = 3'h2;
      2'h2: spacing = 3'h4;
      default: spacing = 3'h1;
    endcase
  endfunction

  always_comb
  begin
    code = adding_q ? p.add_code : p.drop_code;
    space = spacing(code);
    gap_n = gap_q + 3'h1;
  end

  // Mode edges arm a batch; each completed PWM cycle advances it.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      psi_q <= 1'b0;
      adding_q <= 1'b0;
      pending_q <= 3'h0;
      gap_q <= 3'h0;
      p.drop_step <= 1'b0;
      p.add_step <= 1'b0;
      p.all_step <= 1'b0;
    end
    else if (ce)
    begin
      psi_q <= p.psi_active;
      p.drop_step <= 1'b0;
      p.add_step <= 1'b0;
      p.all_step <= 1'b0;
      if (p.psi_active != psi_q)
      begin
        adding_q <= psi_q;
        pending_q <= p.shed_count;
        gap_q <= spacing(psi_q ? p.add_code : p.drop_code) - 3'h1;
      end
      else if (p.pwm_tick && pending_q != 3'h0)
      begin
        if (code == mpsr_pkg::SPACE_ALL)
        begin
          p.all_step <= 1'b1;
          pending_q <= 3'h0;
        end
        else if (gap_n >= space)
        begin
          p.drop_step <= !adding_q;
          p.add_step <= adding_q;
          pending_q <= pending_q - 3'h1;
          gap_q <= 3'h0;
        end
        else
          gap_q <= gap_n;
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  all_at_once_a: assert property (ce && p.pwm_tick && pending_q != 3'h0 && code == 2'h3 && p.psi_active == psi_q |=> p.all_step && pending_q == 3'h0)
    else $error("all phases not changed at once");
  step_spacing_a: assert property (ce && p.drop_step && drop_code_two |=> !p.drop_step)
    else $error("drop steps closer than two cycles");

  // Qualifier for the two-cycle spacing check while shedding.
  assign drop_code_two = (p.drop_code == 2'h1) && !adding_q;
endmodule

// ==== rtl/mpsr_pkg.sv ====
/*
 * Shared constants for the margin and power-save register bank.
 * Assumes nothing beyond a SystemVerilog compiler; every user names items
 * with the package prefix.
 */
package mpsr_pkg;
  // ******************************************************************
  // Serial port identity and register map
  // ******************************************************************
  localparam logic [6:0] DEV_ADDR = 7'h46;
  localparam logic [7:0] REG_NB = 8'h00;
  localparam logic [7:0] REG_CORE = 8'h01;
  localparam logic [7:0] REG_PS = 8'h02;
  localparam int NUM_REGS = 3;
  localparam logic [7:0] RST_NB = 8'h00;
  localparam logic [7:0] RST_CORE = 8'h00;
  localparam logic [7:0] RST_PS = 8'h01;

  // ******************************************************************
  // Field positions
  // ******************************************************************
  localparam int MG_OVP_BIT = 7;
  localparam int MG_PG_BIT = 6;
  localparam int MG_OFF_MSB = 5;
  localparam int PS_DE_BIT = 0;
  localparam int PS_ADD_LSB = 1;
  localparam int PS_DROP_LSB = 3;
  localparam int PS_OFFDIS_BIT = 5;

  // ******************************************************************
  // Thresholds in millivolts
  // ******************************************************************
  localparam logic [12:0] OVP_FLOOR_MV = 13'h0708;
  localparam logic [9:0] OVP_LO_MV = 10'h0fa;
  localparam logic [9:0] OVP_HI_MV = 10'h1f4;
  localparam logic [8:0] PG_CORE_HI0_MV = 9'h0fa;
  localparam logic [8:0] PG_CORE_HI1_MV = 9'h12c;
  localparam logic [8:0] PG_LO0_MV = 9'h12c;
  localparam logic [8:0] PG_LO1_MV = 9'h15e;
  localparam logic [5:0] PG_HYST_MV = 6'h32;
  localparam logic [10:0] OFF_STEP_MV = 11'h019;

  // Phase spacing codes.
  localparam logic [1:0] SPACE_ALL = 2'h3;
endpackage

// ==== rtl/mpsr_regs.sv ====
/*
 * Margin and power-save register bank behind a two-wire serial slave port.
 * Assumes scl and sda arrive unsynchronised from pins, that the pad merges
 * sda_oe_n with sda_out, and that power-savings status and PWM cycle ticks
 * come from logic on core_clk. arst_n is the supply power-on reset.
 */
// Summary of operation
// - Burst write fills registers in address order.
// - Single write: control, address, data, stop.
// - Both margin registers share one bit layout.
// - Bit7 picks overvoltage offset 250 or 500.
// - Bit6 picks the power-good window pair.
// - Every power-good limit carries 50 mV hysteresis.
// - Bits5:0 signed offset, 25 mV per step.
// - Power-save bit0 enables diode emulation.
// - Bits2:1 pace phase adding on exit.
// - Bits4:3 pace phase dropping on entry.
// - Power-save bit5 withdraws offset in that mode.
// - Power-save bits7:6 carry no function.
// - Read: set address, restart, read, nack, stop.
// - Written settings take effect at transaction end.
// - Power-on reset restores 00, 00, 01.
// - Addresses 0, 1, 2 map nb, core, power-save.
`timescale 1ns/1ns
module mpsr_regs (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic ce,
  // Serial port pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // Regulator status
  input wire logic psi_active,
  input wire logic pwm_tick,
  input wire logic [2:0] shed_count,
  input wire logic [11:0] nb_dac_target_voltage,
  input wire logic [11:0] core_dac_target_voltage,
  // Northbridge settings
  output logic [12:0] nb_overvoltage_trip,
  output logic [8:0] nb_pg_low_mv,
  output logic signed [10:0] nb_offset_mv,
  // Core settings
  output logic [12:0] core_overvoltage_trip,
  output logic [8:0] core_pg_high_mv,
  output logic [8:0] core_pg_low_mv,
  output logic [5:0] pg_hyst_mv,
  output logic signed [10:0] core_offset_mv,
  // Power-savings controls
  output logic diode_emul_en,
  output logic phase_drop_step,
  output logic phase_add_step,
  output logic phase_all_step
);
  // ******************************************************************
  // Declarations
  // ******************************************************************
  typedef enum logic [2:0] {
    ST_IDLE, ST_DEVADR, ST_REGADR, ST_WDATA, ST_ACK, ST_RDATA
  } mpsr_state_t;

  mpsr_state_t state_q;
  mpsr_state_t nxt_q;
  logic [2:0] scl_q;
  logic [2:0] sda_q;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic [3:0] cnt_q;
  logic [7:0] sr_q;
  logic [7:0] rd_q;
  logic [7:0] ptr_q;
  logic [7:0] cfg_q [mpsr_pkg::NUM_REGS];
  logic [7:0] shadow_q [mpsr_pkg::NUM_REGS];
  logic [mpsr_pkg::NUM_REGS-1:0] dirty_q;
  logic commit;
  logic de_q;
  logic in_rx;
  logic [7:0] rd_byte;

  mpsr_margin_if nb_if ();
  mpsr_margin_if core_if ();
  mpsr_pace_if pace_if ();

  // Stored value at an address; unmapped addresses read as zero.
  function automatic logic [7:0] reg_at(input logic [7:0] a, input logic [7:0] v0,
                                        input logic [7:0] v1, input logic [7:0] v2);
    case (a)
      mpsr_pkg::REG_NB: reg_at = v0;
      mpsr_pkg::REG_CORE: reg_at = v1;
      mpsr_pkg::REG_PS: reg_at = v2;
      default: reg_at = 8'h00;
    endcase
  endfunction

  // ******************************************************************
  // Pin synchronisers and bus conditions
  // ******************************************************************
  // Stage 0 feeds only stage 1; edges look at stages 1 and 2.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
    end
    else if (ce)
    begin
      scl_q <= {scl_q[1:0], scl_in};
      sda_q <= {sda_q[1:0], sda_in};
    end
  end

  // Start and stop are sda edges while scl stays high.
  always_comb
  begin
    scl_rise = scl_q[1] && !scl_q[2];
    scl_fall = !scl_q[1] && scl_q[2];
    bus_start = scl_q[1] && scl_q[2] && !sda_q[1] && sda_q[2];
    bus_stop = scl_q[1] && scl_q[2] && sda_q[1] && !sda_q[2];
    in_rx = (state_q == ST_DEVADR) || (state_q == ST_REGADR) || (state_q == ST_WDATA);
    commit = (bus_start || bus_stop) && (dirty_q != '0);
    rd_byte = reg_at(ptr_q, cfg_q[0], cfg_q[1], cfg_q[2]);
  end

  // ******************************************************************
  // Transaction sequencer
  // ******************************************************************
  // Bytes shift in on scl rise; acknowledge and read bits change on scl
  // fall, so sda never moves while the master samples it.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= ST_IDLE;
      nxt_q <= ST_IDLE;
      cnt_q <= 4'h0;
      sr_q <= 8'h00;
      rd_q <= 8'h00;
      ptr_q <= 8'h00;
      sda_oe_n <= 1'b1;
    end
    else if (ce)
    begin
      if (bus_start)
      begin
        state_q <= ST_DEVADR;
        cnt_q <= 4'h0;
        sda_oe_n <= 1'b1;
      end
      else if (bus_stop)
      begin
        state_q <= ST_IDLE;
        sda_oe_n <= 1'b1;
      end
      else if (scl_rise)
      begin
        if (in_rx)
        begin
          sr_q <= {sr_q[6:0], sda_q[1]};
          cnt_q <= cnt_q + 4'h1;
        end
        else if (state_q == ST_RDATA)
        begin
          if (cnt_q != 4'h8)
            cnt_q <= cnt_q + 4'h1;
          else if (sda_q[1])
            state_q <= ST_IDLE;
          else
          begin
            ptr_q <= ptr_q + 8'h01;
            rd_q <= reg_at(ptr_q + 8'h01, cfg_q[0], cfg_q[1], cfg_q[2]);
            cnt_q <= 4'h0;
          end
        end
      end
      else if (scl_fall)
      begin
        case (state_q)
          ST_DEVADR:
            if (cnt_q == 4'h8)
            begin
              if (sr_q[7:1] == mpsr_pkg::DEV_ADDR)
              begin
                sda_oe_n <= 1'b0;
                state_q <= ST_ACK;
                nxt_q <= sr_q[0] ? ST_RDATA : ST_REGADR;
              end
              else
                state_q <= ST_IDLE;
            end
          ST_REGADR:
            if (cnt_q == 4'h8)
            begin
              ptr_q <= sr_q;
              sda_oe_n <= 1'b0;
              state_q <= ST_ACK;
              nxt_q <= ST_WDATA;
            end
          ST_WDATA:
            if (cnt_q == 4'h8)
            begin
              ptr_q <= ptr_q + 8'h01;
              sda_oe_n <= 1'b0;
              state_q <= ST_ACK;
              nxt_q <= ST_WDATA;
            end
          ST_ACK:
          begin
            state_q <= nxt_q;
            cnt_q <= 4'h0;
            if (nxt_q == ST_RDATA)
            begin
              sda_oe_n <= rd_byte[7];
              rd_q <= {rd_byte[6:0], 1'b0};
            end
            else
              sda_oe_n <= 1'b1;
          end
          ST_RDATA:
            if (cnt_q == 4'h8)
              sda_oe_n <= 1'b1;
            else
            begin
              sda_oe_n <= rd_q[7];
              rd_q <= {rd_q[6:0], 1'b0};
            end
          default:
            sda_oe_n <= 1'b1;
        endcase
      end
    end
  end

  // The pad only ever pulls low; the enable carries the data.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      sda_out <= 1'b0;
    else if (ce)
      sda_out <= 1'b0;
  end

  // ******************************************************************
  // Register storage
  // ******************************************************************
  // Writes land in a shadow and reach the live registers only when the
  // transaction ends, so a burst never applies a half-written set.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      shadow_q[0] <= mpsr_pkg::RST_NB;
      shadow_q[1] <= mpsr_pkg::RST_CORE;
      shadow_q[2] <= mpsr_pkg::RST_PS;
      dirty_q <= '0;
    end
    else if (ce)
    begin
      if (commit)
        dirty_q <= '0;
      if (scl_fall && state_q == ST_WDATA && cnt_q == 4'h8 && ptr_q < 8'(mpsr_pkg::NUM_REGS))
      begin
        shadow_q[ptr_q[1:0]] <= sr_q;
        dirty_q[ptr_q[1:0]] <= 1'b1;
      end
    end
  end

  generate
    for (genvar i = 0; i < mpsr_pkg::NUM_REGS; i++)
    begin : g_live
      localparam logic [7:0] RV = (i == 2) ? mpsr_pkg::RST_PS : mpsr_pkg::RST_NB;
      always_ff @(posedge core_clk or negedge arst_n)
      begin
        if (!arst_n)
          cfg_q[i] <= RV;
        else if (ce && commit && dirty_q[i])
          cfg_q[i] <= shadow_q[i];
      end
    end
  endgenerate

  // ******************************************************************
  // Settings decode
  // ******************************************************************
  // Offset is withdrawn in power-savings mode only when bit 5 asks;
  // bits 7:6 of that register reach nothing.
  always_comb
  begin
    nb_if.cfg = cfg_q[0];
    core_if.cfg = cfg_q[1];
    nb_if.apply_off = !(psi_active && cfg_q[2][mpsr_pkg::PS_OFFDIS_BIT]);
    core_if.apply_off = nb_if.apply_off;
    nb_if.dac_mv = nb_dac_target_voltage;
    core_if.dac_mv = core_dac_target_voltage;
    pace_if.psi_active = psi_active;
    pace_if.pwm_tick = pwm_tick;
    pace_if.shed_count = shed_count;
    pace_if.drop_code = cfg_q[2][mpsr_pkg::PS_DROP_LSB +: 2];
    pace_if.add_code = cfg_q[2][mpsr_pkg::PS_ADD_LSB +: 2];
  end

  mpsr_margin_dec #(.IS_CORE(1'b0)) u_nb_dec (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .ce(ce),
    .m(nb_if)
  );

  mpsr_margin_dec #(.IS_CORE(1'b1)) u_core_dec (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .ce(ce),
    .m(core_if)
  );

  mpsr_phase_pacer u_pacer (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .ce(ce),
    .p(pace_if)
  );

  // Diode emulation only while in power-savings mode.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      de_q <= 1'b0;
    else if (ce)
      de_q <= psi_active && cfg_q[2][mpsr_pkg::PS_DE_BIT];
  end

  always_comb
  begin
    diode_emul_en = de_q;
    nb_overvoltage_trip = nb_if.ovp_trip_mv;
    nb_pg_low_mv = nb_if.pg_lo_mv;
    nb_offset_mv = nb_if.off_mv;
    core_overvoltage_trip = core_if.ovp_trip_mv;
    core_pg_high_mv = core_if.pg_hi_mv;
    core_pg_low_mv = core_if.pg_lo_mv;
    pg_hyst_mv = core_if.pg_hyst_mv;
    core_offset_mv = core_if.off_mv;
    phase_drop_step = pace_if.drop_step;
    phase_add_step = pace_if.add_step;
    phase_all_step = pace_if.all_step;
  end

  // ******************************************************************
  // Checks
  // ******************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  addr_ack_a: assert property (ce && scl_fall && !bus_start && !bus_stop && state_q == ST_DEVADR && cnt_q == 4'h8 && sr_q[7:1] == 7'h46 |=> !sda_oe_n && state_q == ST_ACK)
    else $error("control byte not acknowledged");
  commit_end_a: assert property (ce && commit && dirty_q[2] |=> cfg_q[2] == $past(shadow_q[2]))
    else $error("written setting not applied at end");
  no_early_apply_a: assert property (ce && !commit |=> cfg_q[1] == $past(cfg_q[1]))
    else $error("setting changed mid transaction");
  read_nack_a: assert property (ce && scl_rise && !bus_start && !bus_stop && state_q == ST_RDATA && cnt_q == 4'h8 && sda_q[1] |=> state_q == ST_IDLE)
    else $error("read not ended by not-acknowledge");
  diode_emul_a: assert property (ce |=> diode_emul_en == ($past(psi_active) && $past(cfg_q[2][0])))
    else $error("diode emulation enable wrong");

  burst_write_c: cover property (commit && dirty_q == 3'h7);
  read_byte_c: cover property (state_q == ST_RDATA ##1 state_q == ST_IDLE);
  shed_step_c: cover property (phase_drop_step);
endmodule
